// ### verilog/lpmc_top.sv
`timescale 1ns/1ps
`include "lpmc_cfg.svh"

module lpmc_top (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 wake,
  output lpmc_pkg::lpmc_mst_e       master_sel,
  output lpmc_pkg::lpmc_osc_s       osc_on,
  output lpmc_pkg::lpmc_pwr_s       pwr
);

  // ----------------------------------------------------------------
  // Oscillator set per master clock and mode
  // ----------------------------------------------------------------
  function automatic lpmc_pkg::lpmc_osc_s osc_set(
    input lpmc_pkg::lpmc_state_e st,
    input lpmc_pkg::lpmc_mst_e   mst,
    input logic                  pe,
    input logic                  me,
    input logic                  se
  );
    lpmc_pkg::lpmc_osc_s o;
    o = '0;
    case (st)
      lpmc_pkg::ST_RTC,
      lpmc_pkg::ST_DSRTC: begin
        o.sub = 1'b1;
      end
      lpmc_pkg::ST_STOP,
      lpmc_pkg::ST_DSSTOP: begin
        o = '0;
      end
      default: begin
        // Run, sleep, timer and the regulator wait share one table
        case (mst)
          lpmc_pkg::MST_HCR:  o = '{sub: se, lcr: 1'b1, pll: pe, main: me, hcr: 1'b1};
          lpmc_pkg::MST_MAIN: o = '{sub: se, lcr: 1'b1, pll: pe, main: 1'b1, hcr: 1'b1};
          // Main kept on as a possible PLL reference
          lpmc_pkg::MST_PLL:  o = '{sub: se, lcr: 1'b1, pll: 1'b1, main: 1'b1, hcr: 1'b1};
          lpmc_pkg::MST_LCR:  o = '{sub: se, lcr: 1'b1, pll: 1'b0, main: 1'b0, hcr: 1'b0};
          lpmc_pkg::MST_SUB:  o = '{sub: 1'b1, lcr: 1'b1, pll: 1'b0, main: 1'b0, hcr: 1'b0};
          default:            o = '0;
        endcase
      end
    endcase
    return o;
  endfunction

  function automatic logic needs_stab(
    input lpmc_pkg::lpmc_state_e st,
    input lpmc_pkg::lpmc_mst_e   mst
  );
    logic slow;
    slow = (mst == lpmc_pkg::MST_LCR) || (mst == lpmc_pkg::MST_SUB);
    return (st == lpmc_pkg::ST_TIMER && slow) || (st >= lpmc_pkg::ST_RTC && st <= lpmc_pkg::ST_DSSTOP);
  endfunction

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  lpmc_pkg::lpmc_state_e state_q;
  lpmc_pkg::lpmc_state_e state_d;
  lpmc_pkg::lpmc_mst_e   mst_q;
  lpmc_pkg::lpmc_mst_e   mst_d;
  logic [31:0]           ctrl_q;
  logic [31:0]           ctrl_d;
  logic                  ret_q;
  logic [11:0]           stab_cnt_q;
  logic [11:0]           stab_len_q;
  logic                  wr_ok;
  logic                  hit;
  logic [31:0]           rd_d;
  logic [2:0]            req_kind;
  logic                  req_acc;

  // Two-cycle access phase keeps pready a plain flop
  always_ff @(posedge clk) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  assign wr_ok = psel && penable && pready && pwrite;
  assign hit   = (paddr == `LPMC_CTRL_OFS) || (paddr == `LPMC_STBY_OFS) || (paddr == `LPMC_STAT_OFS);

  always_comb begin
    rd_d = 32'h0000_0000;
    case (paddr)
      `LPMC_CTRL_OFS: begin
        rd_d = ctrl_q;
      end
      `LPMC_STAT_OFS: begin
        rd_d[`LPMC_STAT_ST_LSB +: 3]  = state_q;
        rd_d[`LPMC_STAT_MST_LSB +: 3] = mst_q;
        rd_d[`LPMC_STAT_OSC_LSB +: 5] = osc_on;
        rd_d[`LPMC_STAT_SRAM]         = pwr.sram_pwr_on;
        rd_d[`LPMC_STAT_CORE]         = pwr.core_pwr_on;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata  <= (psel && penable && !pready && !pwrite) ? rd_d : 32'h0000_0000;
      pslverr <= psel && penable && !pready && !hit;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ok && paddr == `LPMC_CTRL_OFS) begin
      ctrl_d = {25'h0000000, pwdata[6:0] & {`LPMC_RET_AVAIL, 6'h3F}};
      // Unknown master codes keep the current selection
      if (pwdata[2:0] > 3'h4) begin
        ctrl_d[2:0] = ctrl_q[2:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= `LPMC_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  assign req_kind = pwdata[2:0];
  assign req_acc  = wr_ok && paddr == `LPMC_STBY_OFS && state_q == lpmc_pkg::ST_RUN &&
                    req_kind != 3'h0 && req_kind != 3'h7;

  always_comb begin
    state_d = state_q;
    mst_d   = mst_q;
    case (state_q)
      lpmc_pkg::ST_RUN: begin
        // Master follows software only while running
        mst_d = lpmc_pkg::lpmc_mst_e'(ctrl_q[`LPMC_CTRL_MST_LSB +: 3]);
        if (req_acc) begin
          state_d = lpmc_pkg::lpmc_state_e'(req_kind);
        end
      end
      lpmc_pkg::ST_SLEEP,
      lpmc_pkg::ST_TIMER,
      lpmc_pkg::ST_RTC,
      lpmc_pkg::ST_STOP,
      lpmc_pkg::ST_DSRTC,
      lpmc_pkg::ST_DSSTOP: begin
        if (wake) begin
          state_d = needs_stab(state_q, mst_q) ? lpmc_pkg::ST_STAB : lpmc_pkg::ST_RUN;
        end
      end
      lpmc_pkg::ST_STAB: begin
        if (stab_cnt_q == 12'h000) begin
          state_d = lpmc_pkg::ST_RUN;
        end
      end
      default: state_d = lpmc_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= lpmc_pkg::ST_RUN;
      mst_q   <= lpmc_pkg::MST_HCR;
    end else begin
      state_q <= state_d;
      mst_q   <= mst_d;
    end
  end

  // Retention choice is frozen at entry so a late write cannot cut SRAM
  always_ff @(posedge clk) begin
    if (reset) begin
      ret_q <= 1'b0;
    end else if (req_acc) begin
      ret_q <= ctrl_q[`LPMC_CTRL_RET];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      stab_cnt_q <= 12'h000;
    end else if (state_q != lpmc_pkg::ST_STAB) begin
      stab_cnt_q <= 12'(`LPMC_STAB_CYC - 1);
    end else if (stab_cnt_q != 12'h000) begin
      stab_cnt_q <= stab_cnt_q - 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // Clock and power outputs, aligned with the state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      master_sel <= lpmc_pkg::MST_HCR;
      osc_on     <= '{sub: 1'b0, lcr: 1'b1, pll: 1'b0, main: 1'b0, hcr: 1'b1};
    end else begin
      master_sel <= mst_d;
      osc_on     <= osc_set(state_d, mst_d, ctrl_d[`LPMC_CTRL_PLL_ENABLE], ctrl_d[`LPMC_CTRL_MAIN_OSC_ENABLE],
                            ctrl_d[`LPMC_CTRL_SUB_OSC_ENABLE]);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pwr <= '{cpu_clk_en: 1'b1, bus_clk_en: 1'b1, timer_fn_en: 1'b1, rtc_en: 1'b1,
               lvd_en: 1'b1, core_pwr_on: 1'b1, sram_pwr_on: 1'b1};
    end else begin
      pwr.cpu_clk_en  <= state_d == lpmc_pkg::ST_RUN;
      pwr.bus_clk_en  <= state_d == lpmc_pkg::ST_RUN || state_d == lpmc_pkg::ST_SLEEP;
      pwr.timer_fn_en <= state_d <= lpmc_pkg::ST_TIMER || state_d == lpmc_pkg::ST_STAB;
      pwr.rtc_en      <= state_d != lpmc_pkg::ST_STOP && state_d != lpmc_pkg::ST_DSSTOP;
      pwr.lvd_en      <= 1'b1;
      pwr.core_pwr_on <= state_d != lpmc_pkg::ST_DSRTC && state_d != lpmc_pkg::ST_DSSTOP;
      pwr.sram_pwr_on <= (state_d != lpmc_pkg::ST_DSRTC && state_d != lpmc_pkg::ST_DSSTOP) ||
                         (req_acc ? ctrl_q[`LPMC_CTRL_RET] : ret_q);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_hcr_sleep;
    @(posedge clk) disable iff (reset)
      state_q == lpmc_pkg::ST_SLEEP && mst_q == lpmc_pkg::MST_HCR |->
        osc_on.hcr && osc_on.lcr && osc_on.pll == ctrl_q[`LPMC_CTRL_PLL_ENABLE];
  endproperty
  a_hcr_sleep: assert property (p_hcr_sleep) else $error("fast-RC sleep oscillators wrong");
  property p_main_stby;
    @(posedge clk) disable iff (reset)
      state_q inside {lpmc_pkg::ST_SLEEP, lpmc_pkg::ST_TIMER} && mst_q == lpmc_pkg::MST_MAIN |->
        osc_on.main && osc_on.hcr && osc_on.lcr && osc_on.sub == ctrl_q[`LPMC_CTRL_SUB_OSC_ENABLE];
  endproperty
  a_main_stby: assert property (p_main_stby) else $error("main standby oscillators wrong");
  property p_slow_masters;
    @(posedge clk) disable iff (reset)
      state_q inside {lpmc_pkg::ST_SLEEP, lpmc_pkg::ST_TIMER} &&
      mst_q inside {lpmc_pkg::MST_LCR, lpmc_pkg::MST_SUB} |-> !osc_on.hcr && !osc_on.main && !osc_on.pll;
  endproperty
  a_slow_masters: assert property (p_slow_masters) else $error("fast oscillators on in slow standby");
  property p_timer_clocks;
    @(posedge clk) disable iff (reset)
      state_q == lpmc_pkg::ST_TIMER |-> !pwr.cpu_clk_en && !pwr.bus_clk_en && pwr.timer_fn_en;
  endproperty
  a_timer_clocks: assert property (p_timer_clocks) else $error("timer mode clocks wrong");
  property p_sleep_bus;
    @(posedge clk) disable iff (reset)
      state_q == lpmc_pkg::ST_SLEEP |-> !pwr.cpu_clk_en && pwr.bus_clk_en;
  endproperty
  a_sleep_bus: assert property (p_sleep_bus) else $error("sleep mode clocks wrong");
  property p_stop_all;
    @(posedge clk) disable iff (reset)
      state_q inside {lpmc_pkg::ST_STOP, lpmc_pkg::ST_DSSTOP} |-> osc_on == '0 && pwr.lvd_en && !pwr.rtc_en;
  endproperty
  a_stop_all: assert property (p_stop_all) else $error("stop mode left something running");
  property p_rtc_sub;
    @(posedge clk) disable iff (reset)
      state_q inside {lpmc_pkg::ST_RTC, lpmc_pkg::ST_DSRTC} |-> osc_on == 5'h10 && pwr.rtc_en;
  endproperty
  a_rtc_sub: assert property (p_rtc_sub) else $error("rtc mode oscillators wrong");
  property p_deep_pwr;
    @(posedge clk) disable iff (reset)
      state_q inside {lpmc_pkg::ST_DSRTC, lpmc_pkg::ST_DSSTOP} |->
        !pwr.core_pwr_on && pwr.sram_pwr_on == ret_q;
  endproperty
  a_deep_pwr: assert property (p_deep_pwr) else $error("deep standby power wrong");
  // Wait length counted apart from the sequencer's counter, too long for a delay range
  always_ff @(posedge clk) begin
    if (reset || state_q != lpmc_pkg::ST_STAB) begin
      stab_len_q <= 12'h000;
    end else begin
      stab_len_q <= stab_len_q + 12'h001;
    end
  end
  property p_stab_len;
    @(posedge clk) disable iff (reset)
      stab_len_q != 12'h000 |-> ((state_q == lpmc_pkg::ST_STAB) ?
        (!pwr.cpu_clk_en && stab_len_q < 12'(`LPMC_STAB_CYC)) :
        (state_q == lpmc_pkg::ST_RUN && stab_len_q == 12'(`LPMC_STAB_CYC)));
  endproperty
  a_stab_len: assert property (p_stab_len) else $error("regulator wait length wrong");
  property p_resume_master;
    @(posedge clk) disable iff (reset)
      state_q != lpmc_pkg::ST_RUN ##1 state_q == lpmc_pkg::ST_RUN |-> master_sel == $past(mst_q);
  endproperty
  a_resume_master: assert property (p_resume_master) else $error("wake master changed");
  property p_latch;
    @(posedge clk) disable iff (reset)
      req_acc |=> mst_q == $past(ctrl_q[2:0]) && state_q != lpmc_pkg::ST_RUN;
  endproperty
  a_latch: assert property (p_latch) else $error("master not latched at entry");

endmodule // lpmc_top

// ### shared/lpmc_cfg.svh
`ifndef LPMC_CFG_SVH
`define LPMC_CFG_SVH

// Register byte offsets
`define LPMC_CTRL_OFS     12'h000
`define LPMC_STBY_OFS     12'h004
`define LPMC_STAT_OFS     12'h008

// Control register fields
`define LPMC_CTRL_MST_LSB 0
`define LPMC_CTRL_PLL_ENABLE    3
`define LPMC_CTRL_MAIN_OSC_ENABLE   4
`define LPMC_CTRL_SUB_OSC_ENABLE   5
`define LPMC_CTRL_RET     6
`define LPMC_CTRL_RST     32'h0000_0000

// Status register fields
`define LPMC_STAT_ST_LSB  0
`define LPMC_STAT_MST_LSB 3
`define LPMC_STAT_OSC_LSB 6
`define LPMC_STAT_SRAM    11
`define LPMC_STAT_CORE    12

// SRAM retention offered on this variant
`define LPMC_RET_AVAIL    1'b1

// Regulator stabilisation wait
`define LPMC_CLK_MHZ      10
`define LPMC_STAB_US      300
`define LPMC_STAB_CYC     (`LPMC_STAB_US * `LPMC_CLK_MHZ)

`endif

// ### shared/lpmc_pkg.sv
package lpmc_pkg;

  typedef enum logic [2:0] {
    ST_RUN    = 3'h0,
    ST_SLEEP  = 3'h1,
    ST_TIMER  = 3'h2,
    ST_RTC    = 3'h3,
    ST_STOP   = 3'h4,
    ST_DSRTC  = 3'h5,
    ST_DSSTOP = 3'h6,
    ST_STAB   = 3'h7
  } lpmc_state_e;

  typedef enum logic [2:0] {
    MST_HCR  = 3'h0,
    MST_MAIN = 3'h1,
    MST_PLL  = 3'h2,
    MST_LCR  = 3'h3,
    MST_SUB  = 3'h4
  } lpmc_mst_e;

  typedef struct packed {
    logic sub;
    logic lcr;
    logic pll;
    logic main;
    logic hcr;
  } lpmc_osc_s;

  typedef struct packed {
    logic cpu_clk_en;
    logic bus_clk_en;
    logic timer_fn_en;
    logic rtc_en;
    logic lvd_en;
    logic core_pwr_on;
    logic sram_pwr_on;
  } lpmc_pwr_s;

endpackage

// ### testbench/low_power_mode_controller_bench.sv
`timescale 1ns/1ps
`include "lpmc_cfg.svh"

module low_power_mode_controller_bench;
  logic                clk;
  logic                reset;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [11:0]         paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                wake;
  lpmc_pkg::lpmc_mst_e master_sel;
  lpmc_pkg::lpmc_osc_s osc_on;
  lpmc_pkg::lpmc_pwr_s pwr;
  int                  fail_count = 0;
  int                  checks = 0;
  int                  cyc = 0;
  logic [31:0]         rd;
  logic                er;
  logic [2:0]          en;
  logic [2:0]          k;
  logic                r;

  lpmc_top DUT (
    .clk       (clk),
    .reset     (reset),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .wake      (wake),
    .master_sel(master_sel),
    .osc_on    (osc_on),
    .pwr       (pwr)
  );

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // ----------------------------------------
  // Expected values
  // ----------------------------------------
  // Enables ordered {sub, main, pll}; result ordered {sub, lcr, pll, main, hcr}
  function automatic logic [4:0] osc_exp(input logic [2:0] m, input logic [2:0] e);
    case (m)
      3'h0: return {e[2], 1'b1, e[0], e[1], 1'b1};
      3'h1: return {e[2], 1'b1, e[0], 2'b11};
      3'h2: return {e[2], 4'hF};
      3'h3: return {e[2], 4'h8};
      default: return 5'h18;
    endcase
  endfunction

  function automatic logic [6:0] pwr_exp(input logic [2:0] kind, input logic ret);
    case (kind)
      3'h1: return 7'h3F;
      3'h2: return 7'h1F;
      3'h3: return 7'h0F;
      3'h4: return 7'h07;
      3'h5: return {6'h06, ret};
      3'h6: return {6'h02, ret};
      default: return 7'h7F;
    endcase
  endfunction

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Starts on an edge so a release and a new setup never share a time step
  task automatic rw(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Answer is read once settled; the next edge samples it high and completes the transfer
    do begin
      @(posedge clk);
      #1;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wake_up(input logic slow);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    if (slow) begin
      repeat (`LPMC_STAB_CYC - 10) @(posedge clk);
      #1;
      cmp(32'(pwr.cpu_clk_en), 32'h0);
      repeat (20) @(posedge clk);
    end
    #1;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    reset   = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    wake    = 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    cmp(32'(master_sel), 32'h0);
    cmp(32'(osc_on), 32'h09);
    cmp(32'(pwr), 32'h7F);
    rw(1'b0, `LPMC_STAT_OFS, 32'h0);
    cmp(rd, 32'h1A40);
    rw(1'b0, 12'h0FC, 32'h0);
    cmp({31'h0, er}, 32'h1);
    rw(1'b1, `LPMC_CTRL_OFS, 32'h0000_007F);
    rw(1'b0, `LPMC_CTRL_OFS, 32'h0);
    cmp(rd, 32'h0000_0078);
    rw(1'b1, `LPMC_STBY_OFS, 32'h0000_0007);
    #1;
    cmp(32'(pwr), 32'h7F);
    $display("Test reset done");

    for (int e = 0; e < 2; e++) begin
      en = e ? 3'h2 : 3'h5;
      for (int m = 0; m < 5; m++) begin
        for (int j = 1; j < 3; j++) begin
          k = 3'(j);
          rw(1'b1, `LPMC_CTRL_OFS, {26'h0, en, 3'(m)});
          repeat (2) @(posedge clk);
          rw(1'b1, `LPMC_STBY_OFS, 32'(k));
          #1;
          cmp(32'(osc_on), 32'(osc_exp(3'(m), en)));
          cmp(32'(pwr), 32'(pwr_exp(k, 1'b0)));
          rw(1'b1, `LPMC_CTRL_OFS, {26'h0, en, 3'((m + 1) % 5)});
          #1;
          cmp(32'(master_sel), 32'(m));
          rw(1'b1, `LPMC_CTRL_OFS, {26'h0, en, 3'(m)});
          wake_up(k == 3'h2 && m > 2);
          cmp(32'(master_sel), 32'(m));
          cmp(32'(pwr), 32'h7F);
        end
      end
    end
    $display("Test run and standby variants done");

    for (int i = 0; i < 6; i++) begin
      k = (i < 4) ? 3'(i + 3) : 3'(i + 1);
      r = (i >= 4);
      rw(1'b1, `LPMC_CTRL_OFS, {25'h0, r, 6'h0});
      rw(1'b1, `LPMC_STBY_OFS, 32'(k));
      #1;
      cmp(32'(osc_on), (k == 3'h3 || k == 3'h5) ? 32'h10 : 32'h0);
      cmp(32'(pwr), 32'(pwr_exp(k, r)));
      @(posedge clk);
      wake_up(1'b1);
      cmp(32'(pwr), 32'h7F);
    end
    $display("Test deep and stop modes done");
    print_verdict();
  end
endmodule // low_power_mode_controller_bench
